// ===== common/ioexc_regs.svh
`ifndef IOEXC_REGS_SVH
`define IOEXC_REGS_SVH

// ----------------------------------------------------------------------
// widths and pointer values
// ----------------------------------------------------------------------
`define IOEXC_PORT_W 8
`define IOEXC_PTR_W 8
`define IOEXC_PTR_INPUT 8'h00
`define IOEXC_PTR_RST 8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IOEXC_SYS_CLK_MHZ 100
`define IOEXC_INT_VALID_US 4
`define IOEXC_INT_RESET_US 4
`define IOEXC_INT_VALID_CYC (`IOEXC_INT_VALID_US * `IOEXC_SYS_CLK_MHZ)
`define IOEXC_INT_RESET_CYC (`IOEXC_INT_RESET_US * `IOEXC_SYS_CLK_MHZ)

`endif

// ===== common/ioexc_pkg.sv
`include "ioexc_regs.svh"

package ioexc_pkg;

  typedef logic [`IOEXC_PORT_W-1:0] ioexc_port_t;
  typedef logic [`IOEXC_PTR_W-1:0] ioexc_ptr_t;

  typedef enum logic {
    IOEXC_QUIET,
    IOEXC_ACTIVE
  } ioexc_int_state_e;

endpackage : ioexc_pkg

// ===== core/ioexc_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module ioexc_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_d;
      sync_reg <= meta_reg;
    end
  end

  assign o_q = sync_reg;

endmodule : ioexc_sync2

`default_nettype wire

// ===== core/ioexc_int_ctrl.sv
// Function
// - reading the input register releases the change interrupt
// - interrupt releases when all inputs return to last read values
// - pointer at 00h plus foreign read address acknowledge releases interrupt
// - foreign-read clear needs only pointer at 00h, not an actual read
// - reset release initialises all registers and serial state to defaults
// - i_sys_rst is an asynchronous reset of both domains, used at power-up or mid-run
// - interrupt asserts and releases within 4 us of its cause
`timescale 1ns/100ps
`default_nettype none
`include "ioexc_regs.svh"

module ioexc_int_ctrl
  import ioexc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl_clk,
  input wire logic [`IOEXC_PORT_W-1:0] i_port_pins,
  input wire logic [`IOEXC_PORT_W-1:0] i_dir_input,
  input wire logic i_lnk_ptr_wr,
  input wire logic [`IOEXC_PTR_W-1:0] i_lnk_ptr_val,
  input wire logic i_lnk_inreg_rd,
  input wire logic i_lnk_foreign_rd_ack,
  output logic o_int_n_out,
  output logic o_int_n_oe,
  output logic [`IOEXC_PORT_W-1:0] o_input_snap
);

  localparam int ValidCyc = `IOEXC_INT_VALID_CYC;
  localparam int ResetCyc = `IOEXC_INT_RESET_CYC;

  // --------------------------------------------------------------------
  // link domain: pointer and clear events
  // --------------------------------------------------------------------
  ioexc_ptr_t ptr_reg, ptr_next;
  logic rd_tgl_reg, rd_tgl_next;
  logic frd_tgl_reg, frd_tgl_next;
  logic ptr_is_input;

  always_comb begin
    ptr_is_input = (ptr_reg == `IOEXC_PTR_INPUT);
    ptr_next = ptr_reg;
    if (i_lnk_ptr_wr) begin
      ptr_next = i_lnk_ptr_val;
    end
    rd_tgl_next = rd_tgl_reg ^ i_lnk_inreg_rd;
    // pointer value alone arms the foreign clear
    frd_tgl_next = frd_tgl_reg ^ (i_lnk_foreign_rd_ack & ptr_is_input);
  end

  always_ff @(posedge i_scl_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr_reg <= `IOEXC_PTR_RST;
      rd_tgl_reg <= 1'b0;
      frd_tgl_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      rd_tgl_reg <= rd_tgl_next;
      frd_tgl_reg <= frd_tgl_next;
    end
  end

  // --------------------------------------------------------------------
  // crossing: port pins as levels, link events as toggles
  // --------------------------------------------------------------------
  logic [`IOEXC_PORT_W+1:0] sync_q;
  ioexc_port_t pins_s;
  logic rd_tgl_s, frd_tgl_s;

  ioexc_sync2 #(
    .W(`IOEXC_PORT_W + 2)
  ) u_sync (
    .i_clk(i_sys_clk),
    .i_rst(i_sys_rst),
    .i_d({frd_tgl_reg, rd_tgl_reg, i_port_pins}),
    .o_q(sync_q)
  );

  assign pins_s = sync_q[`IOEXC_PORT_W-1:0];
  assign rd_tgl_s = sync_q[`IOEXC_PORT_W];
  assign frd_tgl_s = sync_q[`IOEXC_PORT_W+1];

  // --------------------------------------------------------------------
  // system domain: snapshot and interrupt
  // --------------------------------------------------------------------
  logic [1:0] tgl_d_reg, tgl_d_next;
  ioexc_port_t prev_reg, prev_next;
  ioexc_port_t snap_reg, snap_next;
  logic primed_reg, primed_next;
  logic [1:0] warm_reg, warm_next;
  ioexc_int_state_e state_reg, state_next;
  logic rd_evt, frd_evt, mismatch, change, set_int, clr_int;

  always_comb begin
    rd_evt = rd_tgl_s ^ tgl_d_reg[0];
    frd_evt = frd_tgl_s ^ tgl_d_reg[1];
    mismatch = |((pins_s ^ snap_reg) & i_dir_input);
    change = |((pins_s ^ prev_reg) & i_dir_input);
    tgl_d_next = {frd_tgl_s, rd_tgl_s};
    prev_next = pins_s;
    // hold off until the pin synchroniser shows real levels
    warm_next = warm_reg;
    if (warm_reg != 2'h3) begin
      warm_next = warm_reg + 2'h1;
    end
    primed_next = primed_reg | (warm_reg == 2'h2);
    snap_next = snap_reg;
    // baseline follows the pins until primed, so no false edge
    if (rd_evt || !primed_reg) begin
      snap_next = pins_s;
    end
    set_int = primed_reg & change & mismatch & ~rd_evt;
    clr_int = rd_evt | frd_evt | ~mismatch;
    state_next = state_reg;
    case (state_reg)
      IOEXC_QUIET: begin
        if (set_int) begin
          state_next = IOEXC_ACTIVE;
        end
      end
      IOEXC_ACTIVE: begin
        // a new change in a foreign-read clearing cycle keeps it asserted
        if (clr_int && !set_int) begin
          state_next = IOEXC_QUIET;
        end
      end
      default: begin
        state_next = IOEXC_QUIET;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tgl_d_reg <= 2'h0;
      prev_reg <= '0;
      snap_reg <= '0;
      primed_reg <= 1'b0;
      warm_reg <= 2'h0;
      state_reg <= IOEXC_QUIET;
    end else begin
      tgl_d_reg <= tgl_d_next;
      prev_reg <= prev_next;
      snap_reg <= snap_next;
      primed_reg <= primed_next;
      warm_reg <= warm_next;
      state_reg <= state_next;
    end
  end

  assign o_int_n_out = 1'b0;
  assign o_int_n_oe = (state_reg == IOEXC_ACTIVE);
  assign o_input_snap = snap_reg;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  property p_rd_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    rd_evt |=> !o_int_n_oe && (o_input_snap == $past(pins_s));
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("interrupt not released by input read");

  property p_match_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    primed_reg && !mismatch |=> !o_int_n_oe;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("interrupt held though inputs match last read");

  property p_foreign_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    frd_evt && !set_int |=> !o_int_n_oe;
  endproperty
  a_foreign_clear: assert property (p_foreign_clear)
    else $error("interrupt not released by foreign read");

  property p_foreign_arm;
    @(posedge i_scl_clk) disable iff (i_sys_rst)
    i_lnk_foreign_rd_ack |=>
      (frd_tgl_reg != $past(frd_tgl_reg)) ==
      ($past(ptr_reg) == `IOEXC_PTR_INPUT);
  endproperty
  a_foreign_arm: assert property (p_foreign_arm)
    else $error("foreign read clear armed wrongly");

  property p_reset_init;
    @(posedge i_sys_clk)
    $past(i_sys_rst) |-> !o_int_n_oe && (o_input_snap == '0);
  endproperty
  a_reset_init: assert property (p_reset_init)
    else $error("state not at default after reset");

  property p_assert_time;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    set_int |-> ##[1:ValidCyc] o_int_n_oe;
  endproperty
  a_assert_time: assert property (p_assert_time)
    else $error("interrupt late after input change");

  property p_release_time;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    $changed(rd_tgl_s) && !set_int |-> ##[1:ResetCyc] !o_int_n_oe;
  endproperty
  a_release_time: assert property (p_release_time)
    else $error("interrupt release late after clear");

  property p_hold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_int_n_oe && !rd_evt && !frd_evt && mismatch |=> o_int_n_oe;
  endproperty
  a_hold: assert property (p_hold)
    else $error("interrupt dropped without clear condition");

  c_set: cover property (@(posedge i_sys_clk) $rose(o_int_n_oe));
  c_rd_clear: cover property (@(posedge i_sys_clk) o_int_n_oe && rd_evt);
  c_frd_clear: cover property (@(posedge i_sys_clk) o_int_n_oe && frd_evt);
  c_match: cover property (@(posedge i_sys_clk) o_int_n_oe && !mismatch);

endmodule : ioexc_int_ctrl

`default_nettype wire

// ===== tb/ioexc_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ioexc_ctl_model
  import ioexc_pkg::*;
(
  output logic o_scl,
  output logic o_wr,
  output ioexc_ptr_t o_ptr,
  output logic o_rd,
  output logic o_fack
);
  initial begin
    o_scl = 1'b0;
    {o_fack, o_rd, o_wr} = 3'h0;
    o_ptr = 8'hff;
  end
  // one frame: event on first scl cycle, clock idles low after
  task automatic send(input logic [2:0] ev, input ioexc_ptr_t ptr);
    #7;
    {o_fack, o_rd, o_wr} = ev;
    o_ptr = ptr;
    repeat (3) begin
      #32 o_scl = 1'b1;
      #32 o_scl = 1'b0;
      {o_fack, o_rd, o_wr} = 3'h0;
      o_ptr = ~ptr;
    end
  endtask : send
endmodule : ioexc_ctl_model
`default_nettype wire

// ===== tb/io_expander_interrupt_clear_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
module io_expander_interrupt_clear_logic_tb
  import ioexc_pkg::*;
;
  typedef struct packed {
    ioexc_port_t dir;
    ioexc_port_t pins;
    logic [2:0] ev;
    ioexc_ptr_t ptr;
    logic oe;
    ioexc_port_t snap;
  } ioexc_row_s;
  localparam int N_ROWS = 9;
  // ev bits: foreign ack, input read, pointer write
  ioexc_row_s rows [N_ROWS] = '{
    '{8'hff, 8'h01, 3'h0, 8'h00, 1'b1, 8'h00},
    '{8'hff, 8'h00, 3'h0, 8'h00, 1'b0, 8'h00},
    '{8'hff, 8'h04, 3'h2, 8'h00, 1'b0, 8'h04},
    '{8'h7f, 8'h84, 3'h0, 8'h00, 1'b0, 8'h04},
    '{8'hff, 8'h85, 3'h1, 8'h00, 1'b1, 8'h04},
    '{8'hff, 8'h85, 3'h4, 8'h00, 1'b0, 8'h04},
    '{8'hff, 8'h81, 3'h1, 8'h5a, 1'b1, 8'h04},
    '{8'hff, 8'h81, 3'h4, 8'h00, 1'b1, 8'h04},
    '{8'hff, 8'h81, 3'h2, 8'h00, 1'b0, 8'h81}
  };
  logic clk = 1'b0;
  logic rst = 1'b0;
  ioexc_port_t pins = 8'h00;
  ioexc_port_t dir = 8'hff;
  ioexc_port_t snap;
  ioexc_ptr_t ptr;
  logic scl, wr, rd, fack, int_n_out, int_n_oe;
  int failures = 0;
  int n_compared = 0;
  // open-drain pin with pull-up
  wire logic int_n = int_n_oe ? int_n_out : 1'b1;
  ioexc_ctl_model ctl (.o_scl(scl), .o_wr(wr), .o_ptr(ptr), .o_rd(rd),
    .o_fack(fack));
  ioexc_int_ctrl DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_scl_clk(scl),
    .i_port_pins(pins), .i_dir_input(dir), .i_lnk_ptr_wr(wr),
    .i_lnk_ptr_val(ptr), .i_lnk_inreg_rd(rd), .i_lnk_foreign_rd_ack(fack),
    .o_int_n_out(int_n_out), .o_int_n_oe(int_n_oe), .o_input_snap(snap));
  task automatic chk_bit(input string what, input logic exp,
    input logic got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_port(input string what, input ioexc_port_t exp,
    input ioexc_port_t got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_port
  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    failures++;
    finish_test();
  end
  initial begin
    // async reset of the link side needs a real rising edge
    #1 rst = 1'b1;
    settle(20);
    rst = 1'b0;
    settle(6);
    for (int i = 0; i < N_ROWS; i++) begin
      dir = rows[i].dir;
      pins = rows[i].pins;
      settle(6);
      if (rows[i].ev != 3'h0) begin
        ctl.send(rows[i].ev, rows[i].ptr);
        settle(2);
      end
      chk_bit("int_n", ~rows[i].oe, int_n);
      chk_port("snap", rows[i].snap, snap);
    end
    // mid-run reset clears interrupt, snapshot and pointer
    pins = 8'h00;
    settle(6);
    chk_bit("int_n", 1'b0, int_n);
    rst = 1'b1;
    settle(1);
    chk_bit("int_n", 1'b1, int_n);
    chk_port("snap", 8'h00, snap);
    settle(19);
    // pins already high at release must not look like a change
    pins = 8'h10;
    rst = 1'b0;
    settle(6);
    chk_bit("int_n", 1'b1, int_n);
    chk_port("snap", 8'h10, snap);
    pins = 8'h01;
    settle(6);
    chk_bit("int_n", 1'b0, int_n);
    ctl.send(3'h4, 8'h00);
    settle(2);
    chk_bit("int_n", 1'b1, int_n);
    finish_test();
  end
endmodule : io_expander_interrupt_clear_logic_tb
`default_nettype wire
